/* pkg/sws_map.svh */
// Constants for the stop-state wake sequencer: control bit positions and recovery counts.
// Assumes counts are in core clock cycles at 100 MHz.
`ifndef SWS_MAP_SVH
`define SWS_MAP_SVH
// ********************************************************************
// Control and mode bit positions
// ********************************************************************
`define SWS_CTL_KEEP_RUN_BIT   17
`define SWS_CTL_EXT_CLK_BIT    16
`define SWS_MODE_NO_DELAY_BIT  6
// ********************************************************************
// Recovery counts in core cycles
// ********************************************************************
`define SWS_STOP_DELAY_CYC     32'd131072
`define SWS_SHORT_CYC          32'd24
`define SWS_ACTIVE_CYC         32'd8
`define SWS_RELOCK_MAX_CYC     32'd1000
`define SWS_CNT_RESET          32'h00000000
`endif

/* pkg/sws_pkg.sv */
// Types for the stop-state wake sequencer.
// Assumes the constants header is included by users that need numbers.
package sws_pkg;
   typedef enum logic [1:0] {
      SWS_RUN,
      SWS_STOP,
      SWS_RECOVER,
      SWS_RELEASE
   } sws_state_type;
endpackage : sws_pkg

/* verilog/sws_sequencer.sv */
// Stop-state wake sequencer: holds instruction fetch after a wake interrupt until recovery ends.
// Assumes the core asserts stop_request one cycle and the relock indicator comes from the multiplier.
`timescale 1ns/1ps
`include "sws_map.svh"
module sws_sequencer #(
   parameter int unsigned STOP_DELAY_CYC = `SWS_STOP_DELAY_CYC
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        stop_request,
   input  wire logic        wake_interrupt_line_n,
   input  wire logic [23:0] clock_multiplier_control,
   input  wire logic [23:0] operating_mode_word,
   input  wire logic        multiplier_enable,
   input  wire logic        relock_done,
   output logic             fetch_hold,
   output logic             multiplier_shutdown,
   output logic             in_stop
);
   // ********************************************************************
   // Pin synchroniser
   // ********************************************************************
   // Both stages reset to the idle high level, so no false wake follows reset
   logic wake_meta_q, wake_meta_d;
   logic wake_sync_q, wake_sync_d;
   always_comb begin
      wake_meta_d = wake_interrupt_line_n;
      wake_sync_d = wake_meta_q;
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wake_meta_q <= 1'b1;
         wake_sync_q <= 1'b1;
      end else begin
         wake_meta_q <= wake_meta_d;
         wake_sync_q <= wake_sync_d;
      end
   end
   // ********************************************************************
   // Recovery sequencer
   // ********************************************************************
   sws_pkg::sws_state_type state_q, state_d;
   logic [31:0] cnt_q, cnt_d;
   logic [31:0] relock_cnt_q, relock_cnt_d;
   logic        locked_q, locked_d;
   logic        hold_q, hold_d;
   logic        shut_q, shut_d;
   logic        keep_run;
   logic        no_delay;
   logic        need_lock;
   logic [31:0] load_len;
   assign keep_run  = clock_multiplier_control[`SWS_CTL_KEEP_RUN_BIT];
   assign no_delay  = operating_mode_word[`SWS_MODE_NO_DELAY_BIT];
   assign need_lock = multiplier_enable && !keep_run;
   // Delay off or keep-running: short fixed counts; bit 16 needs no extra term
   // Bit 6 is honoured even with the oscillator stopped; keeping it clear is software's duty
   always_comb begin
      if (keep_run) begin
         load_len = `SWS_ACTIVE_CYC;
      end else if (no_delay) begin
         load_len = `SWS_SHORT_CYC;
      end else begin
         load_len = STOP_DELAY_CYC;
      end
   end
   always_comb begin
      state_d      = state_q;
      cnt_d        = cnt_q;
      relock_cnt_d = relock_cnt_q;
      locked_d     = locked_q;
      hold_d       = hold_q;
      shut_d       = shut_q;
      case (state_q)
         sws_pkg::SWS_RUN: begin
            hold_d = 1'b0;
            if (stop_request) begin
               state_d = sws_pkg::SWS_STOP;
               hold_d  = 1'b1;
               shut_d  = need_lock;
            end
         end
         sws_pkg::SWS_STOP: begin
            if (!wake_sync_q) begin
               state_d      = sws_pkg::SWS_RECOVER;
               cnt_d        = load_len - 32'd1;
               relock_cnt_d = `SWS_CNT_RESET;
               locked_d     = !shut_q;
               shut_d       = 1'b0;
            end
         end
         sws_pkg::SWS_RECOVER: begin
            if (!locked_q) begin
               // Lock given up at the bound, so a dead multiplier cannot hang the core
               if (relock_done || relock_cnt_q >= `SWS_RELOCK_MAX_CYC) begin
                  locked_d = 1'b1;
               end
               relock_cnt_d = relock_cnt_q + 32'd1;
               // Delay count at half rate while lock is sought: the tail after lock
               // is then the full delay less half the relock cycles
               if (relock_cnt_q[0] && cnt_q != 32'd0 && !no_delay) begin
                  cnt_d = cnt_q - 32'd1;
               end
            end else if (cnt_q != 32'd0) begin
               // Short count starts only once lock is back
               cnt_d = cnt_q - 32'd1;
            end else begin
               state_d = sws_pkg::SWS_RELEASE;
            end
         end
         default: begin
            hold_d  = 1'b0;
            state_d = sws_pkg::SWS_RUN;
         end
      endcase
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q      <= sws_pkg::SWS_RUN;
         cnt_q        <= `SWS_CNT_RESET;
         relock_cnt_q <= `SWS_CNT_RESET;
         locked_q     <= 1'b1;
         hold_q       <= 1'b0;
         shut_q       <= 1'b0;
      end else begin
         state_q      <= state_d;
         cnt_q        <= cnt_d;
         relock_cnt_q <= relock_cnt_d;
         locked_q     <= locked_d;
         hold_q       <= hold_d;
         shut_q       <= shut_d;
      end
   end
   // ********************************************************************
   // Registered outputs
   // ********************************************************************
   logic in_stop_q, in_stop_d;
   always_comb begin
      in_stop_d = (state_d == sws_pkg::SWS_STOP);
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         in_stop_q <= 1'b0;
      end else begin
         in_stop_q <= in_stop_d;
      end
   end
   assign fetch_hold          = hold_q;
   assign multiplier_shutdown = shut_q;
   assign in_stop             = in_stop_q;
   // ********************************************************************
   // Checks
   // ********************************************************************
   a_wake_starts_count: assert property (@(posedge clk) disable iff (!rstn)
      state_q == sws_pkg::SWS_STOP && !wake_sync_q |=> state_q == sws_pkg::SWS_RECOVER)
      else $error("wake did not start recovery");
   a_active_short: assert property (@(posedge clk) disable iff (!rstn)
      state_q == sws_pkg::SWS_STOP && !wake_sync_q && keep_run && !shut_q
      |=> state_q == sws_pkg::SWS_RECOVER [*8] ##1 state_q == sws_pkg::SWS_RELEASE)
      else $error("keep-running recovery length wrong");
   a_no_delay_len: assert property (@(posedge clk) disable iff (!rstn)
      state_q == sws_pkg::SWS_STOP && !wake_sync_q && !keep_run && no_delay && !shut_q
      |=> ##23 state_q == sws_pkg::SWS_RECOVER ##1 state_q == sws_pkg::SWS_RELEASE)
      else $error("no-delay recovery length wrong");
   a_release_needs_lock: assert property (@(posedge clk) disable iff (!rstn)
      state_q == sws_pkg::SWS_RECOVER && !locked_q |=> state_q != sws_pkg::SWS_RELEASE)
      else $error("released before relock");
   a_shut_in_stop: assert property (@(posedge clk) disable iff (!rstn)
      state_q == sws_pkg::SWS_RUN && stop_request |=> multiplier_shutdown == need_lock)
      else $error("multiplier shutdown wrong");
   a_fetch_held: assert property (@(posedge clk) disable iff (!rstn)
      state_q == sws_pkg::SWS_RECOVER |-> fetch_hold)
      else $error("fetch not held during recovery");
   a_no_lock_off: assert property (@(posedge clk) disable iff (!rstn)
      state_q == sws_pkg::SWS_STOP && !wake_sync_q && !shut_q |=> locked_q)
      else $error("relock awaited with multiplier off");
   a_release_frees: assert property (@(posedge clk) disable iff (!rstn)
      state_q == sws_pkg::SWS_RELEASE |=> !fetch_hold && state_q == sws_pkg::SWS_RUN)
      else $error("fetch not released");
   a_relock_bound: assert property (@(posedge clk) disable iff (!rstn)
      state_q == sws_pkg::SWS_RECOVER |-> relock_cnt_q <= `SWS_RELOCK_MAX_CYC + 32'd1)
      else $error("relock wait exceeded bound");
   a_stop_entry: assert property (@(posedge clk) disable iff (!rstn)
      state_q == sws_pkg::SWS_RUN && stop_request |=> state_q == sws_pkg::SWS_STOP && fetch_hold && in_stop)
      else $error("stop not entered");
   a_stop_waits: assert property (@(posedge clk) disable iff (!rstn)
      state_q == sws_pkg::SWS_STOP && wake_sync_q |=> state_q == sws_pkg::SWS_STOP && fetch_hold)
      else $error("stop left without wake");
   a_in_stop_flag: assert property (@(posedge clk) disable iff (!rstn)
      state_q == sws_pkg::SWS_STOP |-> in_stop)
      else $error("stop flag low in stop");
   a_shut_cleared: assert property (@(posedge clk) disable iff (!rstn)
      state_q == sws_pkg::SWS_STOP && !wake_sync_q |=> !multiplier_shutdown)
      else $error("multiplier left shut after wake");
   // ********************************************************************
   // Count checks
   // ********************************************************************
   a_count_frozen: assert property (@(posedge clk) disable iff (!rstn)
      state_q == sws_pkg::SWS_RECOVER && !locked_q && no_delay |=> $stable(cnt_q))
      else $error("short count ran before lock");
   a_half_rate_even: assert property (@(posedge clk) disable iff (!rstn)
      state_q == sws_pkg::SWS_RECOVER && !locked_q && !relock_cnt_q[0] |=> $stable(cnt_q))
      else $error("delay count too fast during relock");
   a_half_rate_odd: assert property (@(posedge clk) disable iff (!rstn)
      state_q == sws_pkg::SWS_RECOVER && !locked_q && !no_delay && relock_cnt_q[0] && cnt_q != 32'd0
      |=> cnt_q == $past(cnt_q) - 32'd1)
      else $error("delay count stalled during relock");
   a_relock_counts: assert property (@(posedge clk) disable iff (!rstn)
      state_q == sws_pkg::SWS_RECOVER && !locked_q |=> relock_cnt_q == $past(relock_cnt_q) + 32'd1)
      else $error("relock cycles not counted");
   a_lock_forced: assert property (@(posedge clk) disable iff (!rstn)
      state_q == sws_pkg::SWS_RECOVER && !locked_q && relock_cnt_q >= `SWS_RELOCK_MAX_CYC |=> locked_q)
      else $error("relock bound not enforced");
endmodule : sws_sequencer

/* testbench/sws_wake_source.sv */
// Wake source model: drives the active-low wake pin for the sequencer.
// Assumes fire is a one-cycle request from the bench, on the core clock.
`timescale 1ns/1ps
module sws_wake_source (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic fire,
   input  wire logic fetch_hold,
   output logic      wake_interrupt_line_n
);
   logic armed_q;
   // Level held until the core is released, so always long enough
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         armed_q <= 1'b0;
      end else if (fire) begin
         armed_q <= 1'b1;
      end else if (armed_q && !fetch_hold) begin
         armed_q <= 1'b0;
      end
   end
   // Released pin sits at its pull-up level
   assign wake_interrupt_line_n = ~armed_q;
endmodule : sws_wake_source

/* testbench/stop_state_wake_sequencer_test.sv */
// Testbench for the stop-state wake sequencer: recovery lengths per setting.
// Assumes the wake source model and a shortened stop delay of 64 cycles.
`timescale 1ns/1ps
module stop_state_wake_sequencer_test;
   // ********************************************************************
   // Signals and instances
   // ********************************************************************
   logic        clk = 1'b0, rstn = 1'b0, stop_request = 1'b0, fire = 1'b0;
   logic        multiplier_enable = 1'b0, relock_done = 1'b0;
   logic [23:0] clock_multiplier_control = 24'h000000, operating_mode_word = 24'h000000;
   logic        wake_interrupt_line_n, fetch_hold, multiplier_shutdown, in_stop;
   int          n_fail = 0, n_tests = 0, tk, t2, t3, t4, t5, t6;
   always #5 clk = ~clk;
   sws_sequencer #(.STOP_DELAY_CYC(64)) u_sws_sequencer (.clk(clk), .rstn(rstn), .stop_request(stop_request),
      .wake_interrupt_line_n(wake_interrupt_line_n), .clock_multiplier_control(clock_multiplier_control),
      .operating_mode_word(operating_mode_word), .multiplier_enable(multiplier_enable),
      .relock_done(relock_done), .fetch_hold(fetch_hold), .multiplier_shutdown(multiplier_shutdown),
      .in_stop(in_stop));
   sws_wake_source u_sws_wake_source (.clk(clk), .rstn(rstn), .fire(fire), .fetch_hold(fetch_hold),
      .wake_interrupt_line_n(wake_interrupt_line_n));
   // ********************************************************************
   // Tasks
   // ********************************************************************
   task chk(string name, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %0d seen %0d", name, exp, seen);
      end
   endtask : chk
   task conclude;
      if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   // Enter Stop, wake, count cycles until fetch is released; rl=0 means no relock
   task automatic run(logic [23:0] ctl, logic [23:0] mode, logic men, int rl, output int t);
      @(negedge clk);
      clock_multiplier_control = ctl;
      operating_mode_word = mode;
      multiplier_enable = men;
      stop_request = 1'b1;
      @(negedge clk);
      stop_request = 1'b0;
      repeat (3) @(negedge clk);
      chk("in_stop", in_stop, 1);
      chk("shutdown", multiplier_shutdown, men & ~ctl[17]);
      fire = 1'b1;
      @(negedge clk);
      fire = 1'b0;
      t = 1;
      while (fetch_hold === 1'b1 && t < 2000) begin
         if (t == rl) relock_done = 1'b1;
         @(negedge clk);
         t++;
      end
      chk("hold_released", fetch_hold, 0);
      chk("stop_left", in_stop, 0);
      relock_done = 1'b0;
      repeat (3) @(negedge clk);
   endtask : run
   // ********************************************************************
   // Scenarios
   // ********************************************************************
   // Multiplier kept running: 8 cycles plus pin sync and the edges around it
   task t_active;
      run(24'h020000, 24'h000000, 1'b1, 0, tk);
      chk("active_len", tk >= 8 && tk <= 14, 1);
      chk("active_exact", tk, 13);
   endtask : t_active
   task t_ext_no_delay;
      run(24'h010000, 24'h000040, 1'b0, 0, t2);
      chk("no_delay", t2 - tk, 16);
   endtask : t_ext_no_delay
   task t_stop_delay;
      run(24'h000000, 24'h000000, 1'b0, 0, t3);
      chk("stop_delay", t3 - tk, 56);
   endtask : t_stop_delay
   task t_mode_ignored;
      run(24'h020000, 24'h000040, 1'b0, 0, t4);
      chk("mode_ignored", t4, tk);
   endtask : t_mode_ignored
   // Reset in mid-recovery: every output drops at once
   task t_reset_mid;
      @(negedge clk);
      clock_multiplier_control = 24'h000000;
      operating_mode_word = 24'h000000;
      multiplier_enable = 1'b1;
      stop_request = 1'b1;
      @(negedge clk);
      stop_request = 1'b0;
      fire = 1'b1;
      @(negedge clk);
      fire = 1'b0;
      repeat (5) @(negedge clk);
      rstn = 1'b0;
      @(negedge clk);
      chk("rst_hold", fetch_hold, 0);
      chk("rst_shut", multiplier_shutdown, 0);
      chk("rst_stop", in_stop, 0);
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      repeat (3) @(negedge clk);
   endtask : t_reset_mid
   // Delay off: the short count follows relock instead of overlapping it
   task t_relock_short;
      run(24'h000000, 24'h000040, 1'b1, 50, t5);
      chk("relock_short", t5 >= 74 && t5 <= 60 + t2, 1);
   endtask : t_relock_short
   task t_relock_late;
      run(24'h000000, 24'h000000, 1'b1, 100, t6);
      chk("relock_late", t6 > 100 && t6 <= 100 + t2, 1);
   endtask : t_relock_late
   initial begin
      repeat (3) @(negedge clk);
      rstn = 1'b1;
      t_active;
      t_ext_no_delay;
      t_stop_delay;
      t_mode_ignored;
      t_reset_mid;
      t_relock_short;
      t_relock_late;
      conclude;
   end
   // Watchdog, far beyond the few hundred cycles the runs need
   initial begin
      #200000;
      n_fail++;
      conclude;
   end
endmodule : stop_state_wake_sequencer_test
